/* File: fabric_pkg.sv */
package fabric_pkg;

    // Bus transfer and response encodings
    localparam logic [1:0] TR_IDLE   = 2'h0;
    localparam logic [1:0] TR_BUSY   = 2'h1;
    localparam logic [1:0] TR_NONSEQ = 2'h2;
    localparam logic [1:0] TR_SEQ    = 2'h3;
    localparam logic [1:0] RSP_OKAY  = 2'h0;
    localparam logic [1:0] RSP_ERROR = 2'h1;
    localparam logic [1:0] RSP_RETRY = 2'h2;
    localparam logic [1:0] RSP_SPLIT = 2'h3;

    // Directed address map
    localparam logic [31:0] RAM_BASE  = 32'h0000_0000;
    localparam logic [31:0] RAM_LAST  = 32'h0001_ffff;
    localparam logic [31:0] MON_BASE  = 32'h1f02_0000;
    localparam logic [31:0] MON_LAST  = 32'h1f02_ffff;
    localparam logic [31:0] BOOT_BASE = 32'h1fc0_0000;
    localparam logic [31:0] BOOT_LAST = 32'h1fc1_ffff;

    // Configuration register map
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  STATUS_OFS  = 8'h04;
    localparam logic [7:0]  MISADDR_OFS = 8'h08;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [8:0]  CTRL_MASK   = 9'h1ff;
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_DEF_LSB    = 2;
    localparam int          CTRL_RANDENV    = 4;
    localparam int          CTRL_RANDGRANT  = 5;
    localparam int          CTRL_NOSPLIT    = 6;
    localparam int          CTRL_NOERROR    = 7;
    localparam int          CTRL_NORETRY    = 8;
    localparam int          ST_SPLIT_LSB    = 0;
    localparam int          ST_OWNER_LSB    = 4;
    localparam int          ST_MISMATCH     = 8;
    localparam int          ST_TIMEOUT      = 9;

    // Reset values and constants
    localparam logic [1:0]  DUMMY_IDX   = 2'h3;
    localparam logic [1:0]  OWNER_RESET = 2'h0;
    localparam logic [2:0]  GRANT_RESET = 3'h1;
    localparam logic [31:0] LFSR_SEED   = 32'h1357_9bdf;
    localparam logic [31:0] LFSR_TAPS   = 32'h8020_0003;
    localparam int          TIMEOUT_DEFAULT = 100000;

    typedef enum logic [1:0] {
        ARB_PRIORITY = 2'b00,
        ARB_ROUND    = 2'b01,
        ARB_RANDOM   = 2'b10,
        ARB_SPARE    = 2'b11
    } arb_mode_t;

    typedef enum logic [2:0] {
        SEL_RAM      = 3'b000,
        SEL_MON      = 3'b001,
        SEL_BOOT     = 3'b010,
        SEL_FALLBACK = 3'b011,
        SEL_RAND     = 3'b100
    } sel_t;

    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_WAIT  = 2'b01,
        RS_RESP1 = 2'b10,
        RS_RESP2 = 2'b11
    } rs_state_t;

    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [2:0]  hburst;
        logic [31:0] hwdata;
    } mst_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hready;
        logic [1:0]  hresp;
    } slv_rsp_t;

endpackage

/* File: ahb_test_interconnect.sv */
`timescale 1ns/100ps
module ahb_test_interconnect #(
    parameter int NUM_MASTERS    = 3,
    parameter int WAIT_BITS      = 2,
    parameter int TIMEOUT_CYCLES = fabric_pkg::TIMEOUT_DEFAULT
) (
    input  wire  logic                 mclk,
    input  wire  logic                 resetn,
    // Configuration port
    input  wire  logic                 cfg_hsel,
    input  wire  logic [31:0]          cfg_haddr,
    input  wire  logic [1:0]           cfg_htrans,
    input  wire  logic                 cfg_hwrite,
    input  wire  logic [2:0]           cfg_hsize,
    input  wire  logic [31:0]          cfg_hwdata,
    input  wire  logic                 cfg_hready,
    output logic       [31:0]          cfg_hrdata,
    output logic                       cfg_hreadyout,
    output logic       [1:0]           cfg_hresp,
    // Master side
    input  wire  logic [2:0]           m_busreq,
    input  wire  fabric_pkg::mst_req_t m_req [3],
    output logic       [2:0]           m_grant,
    output logic       [1:0]           m_hmaster,
    output fabric_pkg::slv_rsp_t       m_rsp,
    // Slave side: index 0 RAM, 1 monitor, 2 boot memory
    output fabric_pkg::mst_req_t       s_req,
    output logic       [2:0]           s_hsel,
    input  wire  fabric_pkg::slv_rsp_t s_rsp [3],
    input  wire  logic [2:0]           s_hsplit,
    // Randomized slave status
    output logic                       rs_mismatch,
    output logic                       rs_timeout
);

    generate
        if (NUM_MASTERS != 3 || WAIT_BITS < 1 || WAIT_BITS > 8 || TIMEOUT_CYCLES < 2) begin : g_bad
            $error("ahb_test_interconnect: unsupported parameter value");
        end
    endgenerate

    localparam int TCW = 32;

    logic [31:0]                 ctrl_r;
    logic [31:0]                 lfsr_r;
    logic [1:0]                  grant_idx_r;
    logic [2:0]                  grant_r;
    logic [1:0]                  owner_r;
    logic [1:0]                  data_owner_r;
    logic [1:0]                  last_r;
    logic [2:0]                  split_mask_r;
    fabric_pkg::sel_t            dsel_r;
    logic                        fb_err_r;
    logic                        fb_last_r;
    fabric_pkg::rs_state_t       rs_state_r;
    logic [31:0]                 rs_addr_r;
    logic                        rs_write_r;
    logic [WAIT_BITS-1:0]        rs_wait_r;
    logic [1:0]                  rs_resp_r;
    logic [1:0]                  rs_master_r;
    logic [2:0]                  rs_pend_r;
    logic [2:0]                  rs_hsplit_r;
    logic [TCW-1:0]              tmo_cnt_r;
    logic                        mismatch_r;
    logic                        timeout_r;
    logic [31:0]                 misaddr_r;
    logic                        cfg_wr_r;
    logic [7:0]                  cfg_ofs_r;
    logic [31:0]                 cfg_rdata_r;

    fabric_pkg::arb_mode_t       mode;
    logic [1:0]                  def_master;
    logic [2:0]                  cand;
    logic [1:0]                  next_idx;
    logic                        withdraw;
    fabric_pkg::sel_t            asel;
    logic                        hready;
    logic                        aactive;
    logic [2:0]                  hsplit_all;
    logic [1:0]                  rs_choice;
    logic                        rs_start;
    logic                        rs_done;
    logic                        cfg_take;
    logic [31:0]                 status;
    logic [31:0]                 cfg_rsel;

    // Returns the first candidate at or after start, cyclically; DUMMY_IDX if none
    function automatic logic [1:0] pick(input logic [2:0] c, input logic [1:0] start);
        logic [1:0] idx;
        logic [1:0] res;
        res = fabric_pkg::DUMMY_IDX;
        for (int i = 2; i >= 0; i--) begin
            idx = 2'((int'(start) + i) % 3);
            if (c[idx]) begin
                res = idx;
            end
        end
        return res;
    endfunction

    function automatic fabric_pkg::sel_t decode(input logic [31:0] a, input logic rand_env);
        if (rand_env) begin
            return fabric_pkg::SEL_RAND;
        end else if (a <= fabric_pkg::RAM_LAST) begin
            return fabric_pkg::SEL_RAM;
        end else if (a >= fabric_pkg::MON_BASE && a <= fabric_pkg::MON_LAST) begin
            return fabric_pkg::SEL_MON;
        end else if (a >= fabric_pkg::BOOT_BASE && a <= fabric_pkg::BOOT_LAST) begin
            return fabric_pkg::SEL_BOOT;
        end
        return fabric_pkg::SEL_FALLBACK;
    endfunction

    // Random source shared by the grant withdrawal and the randomized slave
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lfsr_r <= fabric_pkg::LFSR_SEED;
        end else begin
            lfsr_r <= (lfsr_r >> 1) ^ (lfsr_r[0] ? fabric_pkg::LFSR_TAPS : 32'h0000_0000);
        end
    end

    // Arbitration
    always_comb begin
        mode       = fabric_pkg::arb_mode_t'(ctrl_r[fabric_pkg::CTRL_MODE_LSB +: 2]);
        def_master = ctrl_r[fabric_pkg::CTRL_DEF_LSB +: 2];
        withdraw   = (mode == fabric_pkg::ARB_RANDOM) && ctrl_r[fabric_pkg::CTRL_RANDGRANT]
                     && lfsr_r[0] && lfsr_r[1];
        cand       = m_busreq & ~split_mask_r;
        if (withdraw) begin
            cand[0] = 1'b0;
        end
        if (mode == fabric_pkg::ARB_PRIORITY) begin
            next_idx = pick(cand, 2'h0);
        end else begin
            next_idx = pick(cand, (last_r == 2'h2 || last_r == fabric_pkg::DUMMY_IDX) ? 2'h0 : last_r + 2'h1);
        end
        if (cand == 3'h0) begin
            // An unsplit default master still owns an idle bus unless the grant is withdrawn; otherwise the dummy does
            if (def_master != fabric_pkg::DUMMY_IDX && !split_mask_r[def_master] && !withdraw) begin
                next_idx = def_master;
            end else begin
                next_idx = fabric_pkg::DUMMY_IDX;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            grant_idx_r <= fabric_pkg::OWNER_RESET;
            grant_r     <= fabric_pkg::GRANT_RESET;
        end else if (hready) begin
            grant_idx_r <= next_idx;
            grant_r     <= (next_idx == fabric_pkg::DUMMY_IDX) ? 3'h0 : 3'(3'h1 << next_idx);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            owner_r      <= fabric_pkg::OWNER_RESET;
            data_owner_r <= fabric_pkg::OWNER_RESET;
            last_r       <= fabric_pkg::OWNER_RESET;
        end else if (hready) begin
            owner_r      <= grant_idx_r;
            data_owner_r <= owner_r;
            if (s_req.htrans == fabric_pkg::TR_NONSEQ && owner_r != fabric_pkg::DUMMY_IDX) begin
                last_r <= owner_r;
            end
        end
    end

    // Split masking: a new split wins over a release in the same cycle
    assign hsplit_all = s_hsplit | rs_hsplit_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            split_mask_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (m_rsp.hresp == fabric_pkg::RSP_SPLIT && !hready && data_owner_r == 2'(i)) begin
                    split_mask_r[i] <= 1'b1;
                end else if (hsplit_all[i]) begin
                    split_mask_r[i] <= 1'b0;
                end
            end
        end
    end

    // Shared address/control from the address owner, write data from the data owner
    always_comb begin
        if (owner_r == fabric_pkg::DUMMY_IDX) begin
            s_req = '0;
        end else begin
            s_req = m_req[owner_r];
        end
        s_req.hwdata = (data_owner_r == fabric_pkg::DUMMY_IDX) ? 32'h0000_0000 : m_req[data_owner_r].hwdata;
    end

    // Decoding
    always_comb begin
        asel    = decode(s_req.haddr, ctrl_r[fabric_pkg::CTRL_RANDENV]);
        aactive = s_req.htrans[1];
        s_hsel  = 3'h0;
        if (asel == fabric_pkg::SEL_RAM || asel == fabric_pkg::SEL_MON || asel == fabric_pkg::SEL_BOOT) begin
            s_hsel[asel[1:0]] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dsel_r <= fabric_pkg::SEL_FALLBACK;
        end else if (hready) begin
            dsel_r <= asel;
        end
    end

    // Fallback slave: two-cycle ERROR for real transfers, zero-wait OKAY otherwise
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fb_err_r  <= 1'b0;
            fb_last_r <= 1'b0;
        end else begin
            fb_err_r  <= hready && aactive && asel == fabric_pkg::SEL_FALLBACK;
            fb_last_r <= fb_err_r;
        end
    end

    // Response multiplexer
    always_comb begin
        unique case (dsel_r)
            fabric_pkg::SEL_RAM, fabric_pkg::SEL_MON, fabric_pkg::SEL_BOOT: begin
                m_rsp = s_rsp[dsel_r[1:0]];
            end
            fabric_pkg::SEL_RAND: begin
                m_rsp.hrdata = rs_addr_r;
                m_rsp.hready = rs_state_r == fabric_pkg::RS_IDLE || rs_state_r == fabric_pkg::RS_RESP2;
                m_rsp.hresp  = (rs_state_r == fabric_pkg::RS_RESP1 || rs_state_r == fabric_pkg::RS_RESP2)
                               ? rs_resp_r : fabric_pkg::RSP_OKAY;
            end
            default: begin
                m_rsp.hrdata = 32'h0000_0000;
                m_rsp.hready = !fb_err_r;
                m_rsp.hresp  = (fb_err_r || fb_last_r) ? fabric_pkg::RSP_ERROR : fabric_pkg::RSP_OKAY;
            end
        endcase
        hready = m_rsp.hready;
    end

    // Randomized slave
    always_comb begin
        unique case (lfsr_r[9:8])
            2'h1:    rs_choice = ctrl_r[fabric_pkg::CTRL_NOERROR] ? fabric_pkg::RSP_OKAY : fabric_pkg::RSP_ERROR;
            2'h2:    rs_choice = ctrl_r[fabric_pkg::CTRL_NORETRY] ? fabric_pkg::RSP_OKAY : fabric_pkg::RSP_RETRY;
            2'h3:    rs_choice = (ctrl_r[fabric_pkg::CTRL_NOSPLIT] || owner_r == fabric_pkg::DUMMY_IDX)
                                 ? fabric_pkg::RSP_OKAY : fabric_pkg::RSP_SPLIT;
            default: rs_choice = fabric_pkg::RSP_OKAY;
        endcase
        rs_start = hready && aactive && asel == fabric_pkg::SEL_RAND;
        rs_done  = rs_state_r == fabric_pkg::RS_RESP2;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs_state_r  <= fabric_pkg::RS_IDLE;
            rs_addr_r   <= 32'h0000_0000;
            rs_write_r  <= 1'b0;
            rs_wait_r   <= '0;
            rs_resp_r   <= fabric_pkg::RSP_OKAY;
            rs_master_r <= fabric_pkg::OWNER_RESET;
        end else if (hready) begin
            if (rs_start) begin
                rs_addr_r   <= s_req.haddr;
                rs_write_r  <= s_req.hwrite;
                rs_wait_r   <= lfsr_r[2 +: WAIT_BITS];
                rs_resp_r   <= rs_choice;
                rs_master_r <= owner_r;
                if (lfsr_r[2 +: WAIT_BITS] != '0) begin
                    rs_state_r <= fabric_pkg::RS_WAIT;
                end else begin
                    rs_state_r <= (rs_choice == fabric_pkg::RSP_OKAY) ? fabric_pkg::RS_RESP2 : fabric_pkg::RS_RESP1;
                end
            end else begin
                rs_state_r <= fabric_pkg::RS_IDLE;
            end
        end else begin
            unique case (rs_state_r)
                fabric_pkg::RS_WAIT: begin
                    rs_wait_r <= rs_wait_r - 1'b1;
                    if (rs_wait_r == WAIT_BITS'(1)) begin
                        rs_state_r <= (rs_resp_r == fabric_pkg::RSP_OKAY) ? fabric_pkg::RS_RESP2
                                                                           : fabric_pkg::RS_RESP1;
                    end
                end
                fabric_pkg::RS_RESP1: begin
                    rs_state_r <= fabric_pkg::RS_RESP2;
                end
                default: begin
                    rs_state_r <= fabric_pkg::RS_IDLE;
                end
            endcase
        end
    end

    // Split release after a random delay; a new split wins over release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs_pend_r   <= 3'h0;
            rs_hsplit_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                rs_hsplit_r[i] <= rs_pend_r[i] && lfsr_r[7:5] == 3'h0;
                if (rs_state_r == fabric_pkg::RS_RESP1 && rs_resp_r == fabric_pkg::RSP_SPLIT
                    && rs_master_r == 2'(i)) begin
                    rs_pend_r[i] <= 1'b1;
                end else if (rs_pend_r[i] && lfsr_r[7:5] == 3'h0) begin
                    rs_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Write check and runaway timeout; flags are sticky, a hit wins over a clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mismatch_r <= 1'b0;
            misaddr_r  <= 32'h0000_0000;
        end else if (rs_done && rs_write_r && rs_resp_r == fabric_pkg::RSP_OKAY && s_req.hwdata != rs_addr_r) begin
            mismatch_r <= 1'b1;
            misaddr_r  <= rs_addr_r;
        end else if (cfg_wr_r && cfg_ofs_r == fabric_pkg::STATUS_OFS && cfg_hwdata[fabric_pkg::ST_MISMATCH]) begin
            mismatch_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmo_cnt_r <= '0;
            timeout_r <= 1'b0;
        end else begin
            // Counts only while someone wants the bus and the randomized slave completes nothing
            if (rs_done || m_busreq == 3'h0) begin
                tmo_cnt_r <= '0;
            end else if (tmo_cnt_r != TCW'(TIMEOUT_CYCLES)) begin
                tmo_cnt_r <= tmo_cnt_r + 1'b1;
            end
            if (tmo_cnt_r == TCW'(TIMEOUT_CYCLES - 1)) begin
                timeout_r <= 1'b1;
            end else if (cfg_wr_r && cfg_ofs_r == fabric_pkg::STATUS_OFS && cfg_hwdata[fabric_pkg::ST_TIMEOUT]) begin
                timeout_r <= 1'b0;
            end
        end
    end

    // Configuration slave: zero wait states, always OKAY
    assign cfg_take = cfg_hsel && cfg_htrans[1] && cfg_hready;

    always_comb begin
        status = 32'h0000_0000;
        status[fabric_pkg::ST_SPLIT_LSB +: 3] = split_mask_r;
        status[fabric_pkg::ST_OWNER_LSB +: 2] = owner_r;
        status[fabric_pkg::ST_MISMATCH]       = mismatch_r;
        status[fabric_pkg::ST_TIMEOUT]        = timeout_r;
        unique case (cfg_haddr[7:0])
            fabric_pkg::CTRL_OFS:    cfg_rsel = ctrl_r;
            fabric_pkg::STATUS_OFS:  cfg_rsel = status;
            fabric_pkg::MISADDR_OFS: cfg_rsel = misaddr_r;
            default:                 cfg_rsel = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_wr_r    <= 1'b0;
            cfg_ofs_r   <= 8'h00;
            cfg_rdata_r <= 32'h0000_0000;
        end else begin
            cfg_wr_r <= cfg_take && cfg_hwrite;
            if (cfg_take) begin
                cfg_ofs_r <= cfg_haddr[7:0];
            end
            if (cfg_take && !cfg_hwrite && cfg_haddr[31:8] == 24'h000000) begin
                cfg_rdata_r <= cfg_rsel;
            end else if (cfg_take) begin
                cfg_rdata_r <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= fabric_pkg::CTRL_RESET;
        end else if (cfg_wr_r && cfg_ofs_r == fabric_pkg::CTRL_OFS) begin
            ctrl_r <= {23'h000000, cfg_hwdata[8:0] & fabric_pkg::CTRL_MASK};
        end
    end

    assign cfg_hrdata    = cfg_rdata_r;
    assign cfg_hreadyout = 1'b1;
    assign cfg_hresp     = fabric_pkg::RSP_OKAY;
    assign m_grant       = grant_r;
    assign m_hmaster     = owner_r;
    assign rs_mismatch   = mismatch_r;
    assign rs_timeout    = timeout_r;

endmodule

/* File: fabric_checker_sva.sv */
`timescale 1ns/100ps
module fabric_checker (
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire fabric_pkg::mst_req_t m_req [3],
    input wire logic [2:0]           m_grant,
    input wire logic [1:0]           m_hmaster,
    input wire fabric_pkg::slv_rsp_t m_rsp,
    input wire fabric_pkg::mst_req_t s_req,
    input wire logic [2:0]           s_hsel,
    input wire fabric_pkg::slv_rsp_t s_rsp [3]
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_ram; s_hsel[0] |-> s_req.haddr[31:17] == 15'h0; endproperty
    a_ram: assert property (p_ram) else $error("ram select outside its range");
    property p_mon; s_hsel[1] |-> s_req.haddr[31:16] == 16'h1f02; endproperty
    a_mon: assert property (p_mon) else $error("monitor select outside its range");
    property p_boot; s_hsel[2] |-> s_req.haddr[31:17] == 15'h0fe0; endproperty
    a_boot: assert property (p_boot) else $error("boot select outside its range");
    property p_err; s_req.htrans == fabric_pkg::TR_NONSEQ && s_req.haddr[31:28] == 4'hf && m_rsp.hready |=>
        !m_rsp.hready && m_rsp.hresp == fabric_pkg::RSP_ERROR ##1 m_rsp.hready && m_rsp.hresp == fabric_pkg::RSP_ERROR;
    endproperty
    a_err: assert property (p_err) else $error("fallback did not give two cycle error");
    property p_idle; s_req.htrans == fabric_pkg::TR_IDLE && m_rsp.hready |=> m_rsp.hready && m_rsp.hresp == 2'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle transfer not answered okay");
    property p_mux; s_hsel[0] && s_req.htrans[1] && m_rsp.hready |=> m_rsp.hrdata == s_rsp[0].hrdata; endproperty
    a_mux: assert property (p_mux) else $error("read data not from selected slave");
    property p_addr; m_hmaster != 2'h3 |-> s_req.haddr == m_req[m_hmaster].haddr; endproperty
    a_addr: assert property (p_addr) else $error("address not from owning master");
    property p_own; m_rsp.hready && m_grant[1] |=> m_hmaster == 2'h1; endproperty
    a_own: assert property (p_own) else $error("owner did not follow grant");
    property p_dummy; m_hmaster == 2'h3 |-> s_req.htrans == fabric_pkg::TR_IDLE; endproperty
    a_dummy: assert property (p_dummy) else $error("dummy master not idle");
    property p_hot; $onehot0(m_grant); endproperty
    a_hot: assert property (p_hot) else $error("more than one grant");
endmodule
bind ahb_test_interconnect fabric_checker i_fabric_checker (.mclk, .resetn, .m_req, .m_grant, .m_hmaster,
    .m_rsp, .s_req, .s_hsel, .s_rsp);

/* File: slave_model.sv */
`timescale 1ns/100ps
module slave_model (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire fabric_pkg::mst_req_t s_req,
    input  wire logic [2:0]           s_hsel,
    input  wire logic                 hready,
    input  wire logic                 slow,
    output fabric_pkg::slv_rsp_t      s_rsp [3],
    output logic       [2:0]          s_hsplit
);
    logic [2:0]  dsel_r;
    logic        wait_r;
    logic [31:0] addr_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dsel_r <= 3'h0;
            wait_r <= 1'b0;
            addr_r <= 32'h0;
        end else begin
            wait_r <= 1'b0;
            if (hready) begin
                dsel_r <= s_hsel & {3{s_req.htrans[1]}};
                wait_r <= slow && s_req.htrans[1] && |s_hsel;
                addr_r <= s_req.haddr;
            end
        end
    end
    // Unselected data shows the inverse so a stale value never passes for a read
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            s_rsp[i].hrdata = dsel_r[i] ? addr_r + 32'(i) : ~(addr_r + 32'(i));
            s_rsp[i].hready = !(dsel_r[i] && wait_r);
            s_rsp[i].hresp  = fabric_pkg::RSP_OKAY;
        end
    end
    assign s_hsplit = 3'h0;
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic                 mclk, resetn, cfg_hsel, cfg_hwrite, cfg_hreadyout, slow, rs_mismatch, rs_timeout;
    logic [31:0]          cfg_haddr, cfg_hwdata, cfg_hrdata;
    logic [1:0]           cfg_htrans, cfg_hresp, m_hmaster;
    logic [2:0]           m_busreq, m_grant, s_hsel, s_hsplit;
    fabric_pkg::mst_req_t m_req [3];
    fabric_pkg::mst_req_t s_req;
    fabric_pkg::slv_rsp_t m_rsp;
    fabric_pkg::slv_rsp_t s_rsp [3];
    int                   fails = 0;
    int                   tests_run = 0;
    logic [31:0]          adr [12] = '{32'h0, 32'h1fffc, 32'h1f020000, 32'h1f02fffc, 32'h1fc00000, 32'h1fc1fffc,
        32'h20000, 32'h1f01fffc, 32'h1f030000, 32'h1fbffffc, 32'h1fc20000, 32'hfffffffc};
    int                   unit [12] = '{0, 0, 1, 1, 2, 2, 3, 3, 3, 3, 3, 3};
    ahb_test_interconnect #(.TIMEOUT_CYCLES(50)) i_ahb_test_interconnect (.mclk, .resetn, .cfg_hsel, .cfg_haddr,
        .cfg_htrans, .cfg_hwrite, .cfg_hsize(3'h2), .cfg_hwdata, .cfg_hready(cfg_hreadyout), .cfg_hrdata,
        .cfg_hreadyout, .cfg_hresp, .m_busreq, .m_req, .m_grant, .m_hmaster, .m_rsp, .s_req, .s_hsel, .s_rsp,
        .s_hsplit, .rs_mismatch, .rs_timeout);
    slave_model i_slave_model (.mclk, .resetn, .s_req, .s_hsel, .hready(m_rsp.hready), .slow, .s_rsp, .s_hsplit);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
        cfg_hsel   <= 1'b1;
        cfg_htrans <= fabric_pkg::TR_NONSEQ;
        cfg_haddr  <= {24'h0, ofs};
        cfg_hwrite <= wr;
        do @(posedge mclk); while (cfg_hreadyout !== 1'b1);
        cfg_hsel   <= 1'b0;
        cfg_htrans <= fabric_pkg::TR_IDLE;
        cfg_hwdata <= d;
        do @(posedge mclk); while (cfg_hreadyout !== 1'b1);
        chk("cfg hresp", 32'h0, 32'(cfg_hresp));
        if (!wr) chk("cfg read", d, cfg_hrdata);
    endtask
    task automatic grant_is(input logic [2:0] exp);
        int n;
        n = 0;
        do begin @(posedge mclk); n++; end while (m_grant !== exp && n < 20);
        chk("grant", 32'(exp), 32'(m_grant));
    endtask
    // The bus moves only on hready edges, so every wait below keys on it
    task automatic xfer(input int m, input logic [31:0] a, input int u);
        m_busreq[m] <= 1'b1;
        do @(posedge mclk); while (!(m_grant[m] === 1'b1 && m_rsp.hready === 1'b1));
        m_req[m].htrans <= fabric_pkg::TR_NONSEQ;
        m_req[m].haddr  <= a;
        m_busreq[m]     <= 1'b0;
        do @(posedge mclk); while (m_rsp.hready !== 1'b1);
        m_req[m].htrans <= fabric_pkg::TR_IDLE;
        do @(posedge mclk); while (m_rsp.hready !== 1'b1);
        chk("hresp", (u < 3) ? 32'h0 : 32'h1, 32'(m_rsp.hresp));
        if (u < 3) chk("hrdata", a + 32'(u), m_rsp.hrdata);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #40000;
        fails++;
        results();
    end
    initial begin
        {resetn, cfg_hsel, cfg_hwrite, slow, m_busreq} = '0;
        {cfg_haddr, cfg_hwdata, cfg_htrans} = '0;
        for (int i = 0; i < 3; i++) m_req[i] = '{hsize: 3'h2, default: '0};
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("reset grant", 32'h1, 32'(m_grant));
        cfg(1'b0, fabric_pkg::CTRL_OFS, fabric_pkg::CTRL_RESET);
        cfg(1'b0, 8'h0c, 32'h0);
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            xfer(0, adr[i], unit[i]);
        end
        m_busreq <= 3'b111;
        grant_is(3'b001);
        m_busreq <= 3'b110;
        grant_is(3'b010);
        m_busreq <= 3'b000;
        grant_is(3'b001);
        cfg(1'b1, fabric_pkg::CTRL_OFS, 32'h1);
        cfg(1'b0, fabric_pkg::CTRL_OFS, 32'h1);
        m_busreq <= 3'b111;
        grant_is(3'b010);
        xfer(1, 32'h100, 0);
        grant_is(3'b100);
        xfer(2, 32'h1f020000, 1);
        grant_is(3'b001);
        m_busreq <= 3'b000;
        cfg(1'b1, fabric_pkg::CTRL_OFS, 32'hc);
        grant_is(3'b000);
        @(posedge mclk);
        chk("owner", 32'h3, 32'(m_hmaster));
        // Random map with every error kind suppressed: only OKAY, data echoes the address
        cfg(1'b1, fabric_pkg::CTRL_OFS, 32'h1d0);
        xfer(0, 32'h20000, 0);
        xfer(0, 32'h1fc00000, 0);
        m_busreq <= 3'b010;
        repeat (45) @(posedge mclk);
        chk("timeout early", 32'h0, 32'(rs_timeout));
        repeat (10) @(posedge mclk);
        chk("timeout", 32'h1, 32'(rs_timeout));
        chk("mismatch", 32'h0, 32'(rs_mismatch));
        cfg(1'b1, fabric_pkg::STATUS_OFS, 32'h200);
        cfg(1'b0, fabric_pkg::STATUS_OFS, 32'h10);
        results();
    end
endmodule
